//--- cpwmqc_consts.svh
// constants for the complementary pwm / quadrature count block
// assumes a 32-bit plain register port with 8-bit byte address
`ifndef CPWMQC_CONSTS_SVH
`define CPWMQC_CONSTS_SVH
// ==========================================
// register offsets
`define CPWMQC_A_RUN    8'h00
`define CPWMQC_A_MODE   8'h04
`define CPWMQC_A_STAT   8'h08
`define CPWMQC_A_UCNT   8'h0c
`define CPWMQC_A_LCNT   8'h10
`define CPWMQC_A_QCNT   8'h14
`define CPWMQC_A_PER    8'h18
`define CPWMQC_A_PH1    8'h1c
`define CPWMQC_A_PH2    8'h20
`define CPWMQC_A_PH3    8'h24
`define CPWMQC_A_SH1    8'h28
`define CPWMQC_A_SH2    8'h2c
`define CPWMQC_A_SH3    8'h30
`define CPWMQC_A_QCA    8'h34
`define CPWMQC_A_QCB    8'h38
// ==========================================
// field positions
`define CPWMQC_RUN2     0
`define CPWMQC_RUN3     1
`define CPWMQC_RUN4     2
`define CPWMQC_M_COMP   0
`define CPWMQC_M_QUAD   1
`define CPWMQC_M_DIR_FLAG_SELECT   2
`define CPWMQC_M_BUF    3
`define CPWMQC_M_PSC    6
`define CPWMQC_M_CLR    8
`define CPWMQC_NFLAG    5
`define CPWMQC_F_MA3    0
`define CPWMQC_F_WR4    1
`define CPWMQC_F_MA2    2
`define CPWMQC_F_MB2    3
`define CPWMQC_F_WR2    4
// ==========================================
// values
`define CPWMQC_W        16
`define CPWMQC_ZERO     16'h0000
`define CPWMQC_ONE      16'h0001
`define CPWMQC_ALL1     16'hffff
`define CPWMQC_CLR_A    2'h1
`define CPWMQC_CLR_B    2'h2
`endif

//--- cpwmqc_enc_model.sv
// partner model: quadrature encoder feeding the count inputs
// assumes one step request at a time, taken on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module cpwmqc_enc_model
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic step,
   input  wire logic up,
   input  wire logic slow,
   output var  logic qa,
   output var  logic qb,
   output var  logic busy
);
   logic [1:0] ph_q;
   logic [2:0] gap_q;
   // ==========================================
   // gray walk: one line moves per step, so no double edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_q  <= 2'h0;
         gap_q <= 3'h0;
      end
      else if (gap_q != 3'h0)
         gap_q <= gap_q - 3'h1;
      else if (step)
      begin
         ph_q  <= up ? ph_q + 2'h1 : ph_q - 2'h1;
         gap_q <= slow ? 3'h7 : 3'h4;
      end
   end
   always_comb qa = ph_q[1];
   always_comb qb = ph_q[1] ^ ph_q[0];
   always_comb busy = gap_q != 3'h0;
endmodule : cpwmqc_enc_model
`default_nettype wire

//--- cpwmqc_pkg.sv
// types for the complementary pwm / quadrature count block
// assumes cpwmqc_consts.svh is compiled alongside
package cpwmqc_pkg;
   typedef enum logic [1:0] {
      CPWMQC_UP   = 2'b01,
      CPWMQC_DOWN = 2'b10
   } cpwmqc_dir_type;
   typedef logic [15:0] cpwmqc_word_type;
endpackage : cpwmqc_pkg

//--- cpwmqc_props.sv
// checker: port-level relations of cpwmqc_top
// assumes one CORE_CLK domain with ARST_N async active low
`timescale 1ns/100ps
`default_nettype none
module cpwmqc_props
(
   input wire logic                        CORE_CLK,
   input wire logic                        ARST_N,
   input wire logic [7:0]                  ADDR,
   input wire logic                        WR,
   input wire logic                        RD,
   input wire logic [31:0]                 RDATA,
   input wire logic                        QUAD_INPUT_A,
   input wire logic                        QUAD_INPUT_B,
   input wire cpwmqc_pkg::cpwmqc_word_type QUAD_COUNT,
   input wire logic                        PWM1_POS,
   input wire logic                        PWM1_NEG,
   input wire logic                        PWM2_POS,
   input wire logic                        PWM2_NEG,
   input wire logic                        PWM3_POS,
   input wire logic                        PWM3_NEG
);
   import cpwmqc_pkg::*;
   default clocking dc @(posedge CORE_CLK);
   endclocking
   default disable iff (!ARST_N);
   // ==========================================
   // pins and register port
   pair_excl_a: assert property (
      !(PWM1_POS && PWM1_NEG) && !(PWM2_POS && PWM2_NEG) && !(PWM3_POS && PWM3_NEG))
      else $error("pwm pair active together");
   pos_gap_a: assert property (
      (!$rose(PWM1_POS) || !$past(PWM1_NEG)) && (!$rose(PWM2_POS) || !$past(PWM2_NEG))
      && (!$rose(PWM3_POS) || !$past(PWM3_NEG))) else $error("pos rose without gap");
   neg_gap_a: assert property (
      (!$rose(PWM1_NEG) || !$past(PWM1_POS)) && (!$rose(PWM2_NEG) || !$past(PWM2_POS))
      && (!$rose(PWM3_NEG) || !$past(PWM3_POS))) else $error("neg rose without gap");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h00000000)
      else $error("read data outside read slot");
   unmapped_rd_a: assert property ($past(RD) && $past(ADDR) > 8'h38 |-> RDATA == 32'h0)
      else $error("unmapped read not zero");
   status_width_a: assert property (
      $past(RD) && $past(ADDR) == 8'h08 |-> RDATA[31:5] == 27'h0) else $error("status high bits");
   // a write may load the counter, so steps are judged only away from writes
   quad_step_a: assert property (
      $changed(QUAD_COUNT) && !$past(WR) && !$past(WR, 2) |-> QUAD_COUNT == 16'h0000
      || 16'(QUAD_COUNT - $past(QUAD_COUNT)) inside {16'h0001, 16'hffff}) else $error("quad jump");
   quad_hold_a: assert property (
      (!WR && $stable(QUAD_INPUT_A) && $stable(QUAD_INPUT_B))[*7] |-> $stable(QUAD_COUNT))
      else $error("quad count moved without edge");
endmodule : cpwmqc_props
bind cpwmqc_top cpwmqc_props i_cpwmqc_props
(
   .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
   .QUAD_INPUT_A(QUAD_INPUT_A), .QUAD_INPUT_B(QUAD_INPUT_B), .QUAD_COUNT(QUAD_COUNT),
   .PWM1_POS(PWM1_POS), .PWM1_NEG(PWM1_NEG), .PWM2_POS(PWM2_POS), .PWM2_NEG(PWM2_NEG),
   .PWM3_POS(PWM3_POS), .PWM3_NEG(PWM3_NEG)
);
`default_nettype wire

//--- cpwmqc_top.sv
// complementary three-phase pwm on paired counters plus quadrature counter
// assumes synchronous register master on CORE_CLK; encoder pins are async
//
// Notes on behaviour
// R1: paired counters drive three pos/neg pin pairs, never both active.
// R2: software halts both paired counters before entering complementary mode.
// R3: software uses one prescale, edge select if external, no clear source.
// R4: software zeroes lower counter, preloads upper with offset T, never equal.
// R5: period compare holds upper limit minus one.
// R6: initial phase compares not below T and inside count range.
// R7: counters go down at period match, up again at lower underflow.
// R8: pair toggles on upper, lower, lower, upper matches of its compare.
// R9: phase compare above period gives no match, output held 0% or 100%.
// R10: upper match flag only on increment, lower wrap flag only on underflow.
// R11: shadow copies into compare on period match going up or underflow.
// R12: compare values 0..T-1 allowed only after first period match.
// R13: change compares through shadows; direct writes may corrupt waves.
// R14: no shadow moves across band period-T+1..period at up-to-down turn.
// R15: no shadow moves across band 0..T-1 at down-to-up turn.
// R16: out-of-range and return values written in same count direction.
// R17: shadows written after period match or underflow, or by transfer engine.
// R18: quadrature only on channel 2, pins replace clock, counts both ways.
// R19: channel 2 keeps clear source, compares, flags in quadrature mode.
// R20: software sets quad mode, flag condition, then run bit.
// R21: quadrature counter counts every edge of both inputs.
// R22: up on B rise/A low, A rise/B high, B fall/A high, A fall/B low.
// R23: encoder keeps phase gap 1.5 and pulse width 2.5 timer cycles.
// R24: wrap flag on all-ones to zero up, or zero to all-ones down.
// R25: a flag clears only when read as 1 then written 0.
`include "cpwmqc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module cpwmqc_top
(
   input  wire  logic                        CORE_CLK,
   input  wire  logic                        ARST_N,
   input  wire  logic [7:0]                  ADDR,
   input  wire  logic [31:0]                 WDATA,
   input  wire  logic                        WR,
   input  wire  logic                        RD,
   output var   logic [31:0]                 RDATA,
   input  wire  logic                        QUAD_INPUT_A,
   input  wire  logic                        QUAD_INPUT_B,
   output var   cpwmqc_pkg::cpwmqc_word_type QUAD_COUNT,
   output var   logic                        PWM1_POS,
   output var   logic                        PWM1_NEG,
   output var   logic                        PWM2_POS,
   output var   logic                        PWM2_NEG,
   output var   logic                        PWM3_POS,
   output var   logic                        PWM3_NEG
);
   import cpwmqc_pkg::*;

   // ==========================================
   // helpers
   function automatic logic hit(input cpwmqc_word_type c, input cpwmqc_word_type x,
                                input cpwmqc_word_type p);
      hit = (c == x) && (x <= p); // see R9
   endfunction : hit

   function automatic logic wsel(input logic [7:0] a, input logic [7:0] o);
      wsel = (a == o);
   endfunction : wsel

   // ==========================================
   // registers
   logic [2:0]                run_q;
   logic [9:0]                mode_q;
   logic [`CPWMQC_NFLAG-1:0]  flag_q;
   logic [`CPWMQC_NFLAG-1:0]  armed_q;
   logic [`CPWMQC_NFLAG-1:0]  fset;
   cpwmqc_word_type           ucnt_q;
   cpwmqc_word_type           lcnt_q;
   cpwmqc_word_type           qcnt_q;
   cpwmqc_word_type           per_q;
   cpwmqc_word_type           ph_q [3];
   cpwmqc_word_type           sh_q [3];
   cpwmqc_word_type           qca_q;
   cpwmqc_word_type           qcb_q;
   cpwmqc_dir_type            dir_q;
   logic [2:0]                psc_q;
   logic                      tick;
   logic                      comp_run;
   logic                      quad_run;
   logic                      up_turn;
   logic                      dn_turn;
   logic [2:0]                pos_q;
   logic [2:0]                neg_q;
   logic [1:0]                qa_s;
   logic [1:0]                qb_s;
   logic                      qa_p;
   logic                      qb_p;
   logic                      q_inc;
   logic                      q_dec;
   logic [31:0]               rd_d;

   // ==========================================
   // timer clock enable from core clock divider
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         psc_q <= 3'h0;
      else
         psc_q <= psc_q + 3'h1;
   end

   always_comb
   begin
      case (mode_q[`CPWMQC_M_PSC +: 2])
         2'h0:    tick = 1'b1;
         2'h1:    tick = psc_q[0];
         2'h2:    tick = &psc_q[1:0];
         default: tick = &psc_q;
      endcase
   end

   assign comp_run = mode_q[`CPWMQC_M_COMP] && run_q[`CPWMQC_RUN3]
                     && run_q[`CPWMQC_RUN4];
   assign quad_run = mode_q[`CPWMQC_M_QUAD] && run_q[`CPWMQC_RUN2];
   // turning points; overshoot/undershoot happen on these ticks
   assign up_turn  = comp_run && tick && (dir_q == CPWMQC_UP) && (ucnt_q == per_q);
   assign dn_turn  = comp_run && tick && (dir_q == CPWMQC_DOWN)
                     && (lcnt_q == `CPWMQC_ZERO);

   // ==========================================
   // control registers
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         run_q  <= 3'h0;
         mode_q <= 10'h000;
         per_q  <= `CPWMQC_ALL1;
         qca_q  <= `CPWMQC_ALL1;
         qcb_q  <= `CPWMQC_ALL1;
      end
      else if (WR)
      begin
         if (wsel(ADDR, `CPWMQC_A_RUN))
            run_q <= WDATA[2:0];
         if (wsel(ADDR, `CPWMQC_A_MODE))
            mode_q <= WDATA[9:0];
         if (wsel(ADDR, `CPWMQC_A_PER))
            per_q <= WDATA[15:0];
         if (wsel(ADDR, `CPWMQC_A_QCA))
            qca_q <= WDATA[15:0];
         if (wsel(ADDR, `CPWMQC_A_QCB))
            qcb_q <= WDATA[15:0];
      end
   end

   // ==========================================
   // compare and shadow registers
   // direct compare writes are honoured except in a buffered transfer cycle, and may glitch a running wave
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         for (int i = 0; i < 3; i++)
         begin
            ph_q[i] <= `CPWMQC_ALL1;
            sh_q[i] <= `CPWMQC_ALL1;
         end
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (WR && wsel(ADDR, `CPWMQC_A_SH1 + 8'(4 * i)))
               sh_q[i] <= WDATA[15:0];
            if (mode_q[`CPWMQC_M_BUF + i] && (up_turn || dn_turn))
               ph_q[i] <= sh_q[i]; // see R11
            else if (WR && wsel(ADDR, `CPWMQC_A_PH1 + 8'(4 * i)))
               ph_q[i] <= WDATA[15:0];
         end
      end
   end

   // ==========================================
   // paired up/down counters
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ucnt_q <= `CPWMQC_ZERO;
         lcnt_q <= `CPWMQC_ZERO;
         dir_q  <= CPWMQC_UP;
      end
      else if (comp_run && tick)
      begin
         case (dir_q)
            CPWMQC_UP:
            begin
               ucnt_q <= ucnt_q + `CPWMQC_ONE;
               lcnt_q <= lcnt_q + `CPWMQC_ONE;
               if (up_turn)
                  dir_q <= CPWMQC_DOWN; // see R7
            end
            CPWMQC_DOWN:
            begin
               ucnt_q <= ucnt_q - `CPWMQC_ONE;
               lcnt_q <= lcnt_q - `CPWMQC_ONE;
               if (dn_turn)
                  dir_q <= CPWMQC_UP; // see R7
            end
            default:
               dir_q <= CPWMQC_UP;
         endcase
      end
      else
      begin
         if (WR && wsel(ADDR, `CPWMQC_A_UCNT))
            ucnt_q <= WDATA[15:0];
         if (WR && wsel(ADDR, `CPWMQC_A_LCNT))
            lcnt_q <= WDATA[15:0];
         if (!comp_run)
            dir_q <= CPWMQC_UP;
      end
   end

   // ==========================================
   // complementary outputs; dead time is the counter offset
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pos_q <= 3'h0;
         neg_q <= 3'h0;
      end
      else if (!mode_q[`CPWMQC_M_COMP])
      begin
         pos_q <= 3'h0;
         neg_q <= 3'h0;
      end
      else if (!comp_run)
      begin
         // halted: upper leads, so each phase starts in its positive half
         // neg drops first and pos follows a cycle later, so the gap survives a stop
         pos_q <= ~neg_q; // see R1
         neg_q <= 3'h0;
      end
      else if (tick)
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (dir_q == CPWMQC_UP)
            begin
               if (hit(ucnt_q, ph_q[i], per_q))
                  pos_q[i] <= 1'b0; // see R8
               if (hit(lcnt_q, ph_q[i], per_q) && !pos_q[i])
                  neg_q[i] <= 1'b1; // see R1, R8
            end
            else
            begin
               if (hit(lcnt_q, ph_q[i], per_q))
                  neg_q[i] <= 1'b0; // see R8
               if (hit(ucnt_q, ph_q[i], per_q) && !neg_q[i])
                  pos_q[i] <= 1'b1; // see R1, R8
            end
         end
      end
   end

   // ==========================================
   // encoder inputs, two-flop synchronisers then edge history
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         qa_s <= 2'h0;
         qb_s <= 2'h0;
         qa_p <= 1'b0;
         qb_p <= 1'b0;
      end
      else
      begin
         qa_s <= {qa_s[0], QUAD_INPUT_A};
         qb_s <= {qb_s[0], QUAD_INPUT_B};
         // pins are the count clock; prescale must not gate or lose edges
         qa_p <= qa_s[1]; // see R18
         qb_p <= qb_s[1];
      end
   end

   // both edges of both inputs; pins stand in for the prescaled clock
   always_comb
   begin
      q_inc = (qb_s[1] && !qb_p && !qa_s[1]) || (qa_s[1] && !qa_p && qb_s[1])
           || (!qb_s[1] && qb_p && qa_s[1]) || (!qa_s[1] && qa_p && !qb_s[1]); // see R21, R22
      q_dec = (qb_s[1] && !qb_p && qa_s[1]) || (qa_s[1] && !qa_p && !qb_s[1])
           || (!qb_s[1] && qb_p && !qa_s[1]) || (!qa_s[1] && qa_p && qb_s[1]); // see R22
   end

   // ==========================================
   // quadrature counter with clear source
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         qcnt_q <= `CPWMQC_ZERO;
      else if (quad_run && (q_inc || q_dec)) // see R18
      begin
         if ((mode_q[`CPWMQC_M_CLR +: 2] == `CPWMQC_CLR_A && qcnt_q == qca_q)
             || (mode_q[`CPWMQC_M_CLR +: 2] == `CPWMQC_CLR_B && qcnt_q == qcb_q))
            qcnt_q <= `CPWMQC_ZERO; // see R19
         else if (q_inc)
            qcnt_q <= qcnt_q + `CPWMQC_ONE; // see R18
         else
            qcnt_q <= qcnt_q - `CPWMQC_ONE; // see R18
      end
      else if (WR && wsel(ADDR, `CPWMQC_A_QCNT))
         qcnt_q <= WDATA[15:0];
   end

   // ==========================================
   // status flags; a set in the clearing cycle wins
   always_comb
   begin
      fset = '0;
      fset[`CPWMQC_F_MA3] = up_turn; // see R10
      fset[`CPWMQC_F_WR4] = dn_turn; // see R10
      if (quad_run && (q_inc || q_dec))
      begin
         fset[`CPWMQC_F_MA2] = (qcnt_q == qca_q); // see R19
         fset[`CPWMQC_F_MB2] = (qcnt_q == qcb_q); // see R19
         // flag condition select: set restricts wrap flag to up-count wrap
         fset[`CPWMQC_F_WR2] = (q_inc && qcnt_q == `CPWMQC_ALL1)
                            || (q_dec && qcnt_q == `CPWMQC_ZERO
                                && !mode_q[`CPWMQC_M_DIR_FLAG_SELECT]); // see R24
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         flag_q  <= '0;
         armed_q <= '0;
      end
      else
      begin
         for (int i = 0; i < `CPWMQC_NFLAG; i++)
         begin
            if (fset[i])
               flag_q[i] <= 1'b1;
            else if (WR && wsel(ADDR, `CPWMQC_A_STAT) && armed_q[i] && !WDATA[i])
               flag_q[i] <= 1'b0; // see R25
            if (RD && wsel(ADDR, `CPWMQC_A_STAT) && flag_q[i])
               armed_q[i] <= 1'b1; // see R25
            else if (WR && wsel(ADDR, `CPWMQC_A_STAT))
               armed_q[i] <= 1'b0;
         end
      end
   end

   // ==========================================
   // read back, data in the cycle after the strobe
   always_comb
   begin
      rd_d = 32'h0000_0000;
      case (ADDR)
         `CPWMQC_A_RUN:  rd_d[2:0] = run_q;
         `CPWMQC_A_MODE: rd_d[9:0] = mode_q;
         `CPWMQC_A_STAT: rd_d[`CPWMQC_NFLAG-1:0] = flag_q;
         `CPWMQC_A_UCNT: rd_d[15:0] = ucnt_q;
         `CPWMQC_A_LCNT: rd_d[15:0] = lcnt_q;
         `CPWMQC_A_QCNT: rd_d[15:0] = qcnt_q;
         `CPWMQC_A_PER:  rd_d[15:0] = per_q;
         `CPWMQC_A_PH1:  rd_d[15:0] = ph_q[0];
         `CPWMQC_A_PH2:  rd_d[15:0] = ph_q[1];
         `CPWMQC_A_PH3:  rd_d[15:0] = ph_q[2];
         `CPWMQC_A_SH1:  rd_d[15:0] = sh_q[0];
         `CPWMQC_A_SH2:  rd_d[15:0] = sh_q[1];
         `CPWMQC_A_SH3:  rd_d[15:0] = sh_q[2];
         `CPWMQC_A_QCA:  rd_d[15:0] = qca_q;
         `CPWMQC_A_QCB:  rd_d[15:0] = qcb_q;
         default:        rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         RDATA <= 32'h0000_0000;
      else if (RD)
         RDATA <= rd_d;
      else
         RDATA <= 32'h0000_0000;
   end

   // ==========================================
   // pins straight from flops
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         QUAD_COUNT <= `CPWMQC_ZERO;
         PWM1_POS   <= 1'b0;
         PWM1_NEG   <= 1'b0;
         PWM2_POS   <= 1'b0;
         PWM2_NEG   <= 1'b0;
         PWM3_POS   <= 1'b0;
         PWM3_NEG   <= 1'b0;
      end
      else
      begin
         QUAD_COUNT <= qcnt_q;
         PWM1_POS   <= pos_q[0];
         PWM1_NEG   <= neg_q[0];
         PWM2_POS   <= pos_q[1];
         PWM2_NEG   <= neg_q[1];
         PWM3_POS   <= pos_q[2];
         PWM3_NEG   <= neg_q[2];
      end
   end
endmodule : cpwmqc_top
`default_nettype wire

//--- tb_cpwmqc_top.sv
// testbench: register port, pwm pins and encoder inputs of cpwmqc_top
// assumes design, partner model and checker compiled before this file
`include "cpwmqc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_cpwmqc_top;
   import cpwmqc_pkg::*;
   logic            core_clk, arst_n, wr, rd;
   logic [7:0]      addr;
   logic [31:0]     wdata, rdata;
   logic            qa, qb, step, up, slow, busy;
   cpwmqc_word_type qcount;
   logic [5:0]      pwm;
   int              fails;
   int              comparisons;
   cpwmqc_top i_cpwmqc_top
   (
      .CORE_CLK(core_clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .QUAD_INPUT_A(qa), .QUAD_INPUT_B(qb), .QUAD_COUNT(qcount),
      .PWM1_POS(pwm[0]), .PWM1_NEG(pwm[1]), .PWM2_POS(pwm[2]), .PWM2_NEG(pwm[3]),
      .PWM3_POS(pwm[4]), .PWM3_NEG(pwm[5])
   );
   cpwmqc_enc_model i_cpwmqc_enc_model
   (
      .clk(core_clk), .rst_n(arst_n), .step(step), .up(up), .slow(slow), .qa(qa), .qb(qb),
      .busy(busy)
   );
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ==========================================
   // bus and check helpers; each is entered just after a rising edge
   task automatic finish_test;
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // extra idle edge after each strobe keeps one assignment per time step
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      addr  <= a;
      wdata <= {16'h0000, d};
      wr    <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge core_clk);
   endtask : rd_reg
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      chk(d & m, e);
   endtask : rchk
   task automatic enc(input logic u, input int n, input logic s);
      for (int i = 0; i < n; i++)
      begin
         step <= 1'b1;
         up   <= u;
         slow <= s;
         @(posedge core_clk);
         step <= 1'b0;
         @(posedge core_clk);
         for (int k = 0; k < 20 && busy; k++)
            @(posedge core_clk);
      end
      repeat (6) @(posedge core_clk);
   endtask : enc
   // ==========================================
   // scenarios
   task automatic t_reset;
      logic [7:0]  a [8] = '{`CPWMQC_A_RUN, `CPWMQC_A_MODE, `CPWMQC_A_STAT, `CPWMQC_A_UCNT,
                             `CPWMQC_A_PER, `CPWMQC_A_PH1, `CPWMQC_A_SH3, 8'h3c};
      logic [15:0] e [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'hffff, 16'h0};
      for (int i = 0; i < 8; i++)
         rchk(a[i], 32'hffff, {16'h0000, e[i]});
   endtask : t_reset
   // t=2, period 9: phase1 at 5 with buffer, phase2 at t, phase3 out of range
   task automatic t_pwm;
      int         qr[$], qf[$], nr[$], nf[$];
      int         bad;
      logic [5:0] p;
      wr_reg(`CPWMQC_A_RUN, 16'h0000);
      wr_reg(`CPWMQC_A_MODE, 16'h0009);
      wr_reg(`CPWMQC_A_LCNT, 16'h0000);
      wr_reg(`CPWMQC_A_UCNT, 16'h0002);
      wr_reg(`CPWMQC_A_PER, 16'h0009);
      wr_reg(`CPWMQC_A_SH1, 16'h0005);
      wr_reg(`CPWMQC_A_PH1, 16'h0005);
      wr_reg(`CPWMQC_A_PH2, 16'h0002);
      wr_reg(`CPWMQC_A_PH3, 16'h000a);
      wr_reg(`CPWMQC_A_RUN, 16'h0006);
      bad = 0;
      p = pwm;
      for (int n = 0; n < 120; n++)
      begin
         @(posedge core_clk);
         #1;
         if (pwm[0] && !p[0]) qr.push_back(n);
         if (!pwm[0] && p[0]) qf.push_back(n);
         if (pwm[1] && !p[1]) nr.push_back(n);
         if (!pwm[1] && p[1]) nf.push_back(n);
         if (pwm[5:4] !== 2'b01) bad++;
         if (n == 10) chk({30'h0, pwm[3:2]}, 32'h2);
         if (n == 17) chk({30'h0, pwm[3:2]}, 32'h1);
         p = pwm;
      end
      @(posedge core_clk);
      chk(qr[2] - qr[1], 32'h12);
      chk(nr[1] - qf[1], 32'h2);
      chk(qr[1] - nf[1], 32'h2);
      chk(bad, 32'h0);
      wr_reg(`CPWMQC_A_SH1, 16'h0007);
      repeat (20) @(posedge core_clk);
      rchk(`CPWMQC_A_PH1, 32'hffff, 32'h7);
      rchk(`CPWMQC_A_STAT, 32'h3, 32'h3);
      wr_reg(`CPWMQC_A_STAT, 16'h001f);
      wr_reg(`CPWMQC_A_RUN, 16'h0000);
      wr_reg(`CPWMQC_A_STAT, 16'h0000);
      rchk(`CPWMQC_A_STAT, 32'h3, 32'h3);
      wr_reg(`CPWMQC_A_STAT, 16'h0000);
      rchk(`CPWMQC_A_STAT, 32'h3, 32'h0);
   endtask : t_pwm
   task automatic t_quad;
      wr_reg(`CPWMQC_A_MODE, 16'h00c2);
      wr_reg(`CPWMQC_A_QCA, 16'h0002);
      wr_reg(`CPWMQC_A_RUN, 16'h0001);
      enc(1'b1, 3, 1'b0);
      enc(1'b1, 1, 1'b1);
      chk({16'h0000, qcount}, 32'h4);
      rchk(`CPWMQC_A_STAT, 32'h4, 32'h4);
      enc(1'b0, 6, 1'b1);
      chk({16'h0000, qcount}, 32'hfffe);
      rchk(`CPWMQC_A_STAT, 32'h10, 32'h10);
      wr_reg(`CPWMQC_A_STAT, 16'h0000);
      wr_reg(`CPWMQC_A_MODE, 16'h00c6);
      enc(1'b1, 2, 1'b0);
      rchk(`CPWMQC_A_STAT, 32'h10, 32'h10);
      wr_reg(`CPWMQC_A_STAT, 16'h0000);
      enc(1'b0, 1, 1'b0);
      chk({16'h0000, qcount}, 32'hffff);
      rchk(`CPWMQC_A_STAT, 32'h10, 32'h0);
      // clear on compare a: 0, 1, 2, then the third step clears
      wr_reg(`CPWMQC_A_QCNT, 16'h0000);
      wr_reg(`CPWMQC_A_MODE, 16'h01c2);
      enc(1'b1, 3, 1'b0);
      chk({16'h0000, qcount}, 32'h0);
   endtask : t_quad
   initial
   begin
      fails = 0;
      comparisons = 0;
      arst_n = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      step = 1'b0;
      up = 1'b0;
      slow = 1'b0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      t_reset;
      t_pwm;
      t_quad;
      finish_test;
   end
   // about 370 cycles expected; limit set well above that
   initial
   begin
      #100000;
      fails++;
      finish_test;
   end
endmodule : tb_cpwmqc_top
`default_nettype wire
